/* rtl/vco_cal_and_clock_distribution.sv */
// oscillator calibration controller and five-channel clock distribution with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
module vco_cal_and_clock_distribution
    import vco_cal_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // clock pins
    input  wire logic        referenceInput,
    input  wire logic        extClkIn,
    input  wire logic        oscClkIn,
    // distributed outputs and hold indication
    output logic [4:0]       chanOut,
    output logic             syncHold,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (d & m);
    endfunction
    // calibration divider field decode: 1, 2, 4 or 8
    function automatic logic [3:0] calDivRatio(input logic [1:0] f);
        return 4'h1 << f;
    endfunction
    // pin synchronisers
    logic [2:0] syncA, syncB;
    logic       refPrev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA   <= 3'h0;
            syncB   <= 3'h0;
            refPrev <= 1'b0;
        end else if (ce) begin
            syncA   <= {oscClkIn, extClkIn, referenceInput};
            syncB   <= syncA;
            refPrev <= syncB[0];
        end
    end
    wire logic refRise = syncB[0] & ~refPrev;
    // register state
    logic [31:0] ctrlStage;
    logic [31:0] ctrlAct;
    logic [31:0] rdiv;
    logic [31:0] chanCfg [5];
    logic        calDone, calBusy, calStart;
    // write channel: address and data taken in either order
    logic        awHeld, wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    wire logic   doWrite = awHeld & wHeld & ~s_axi_bvalid;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else if (ce) begin
            s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr > ADDR_CHAN4 || awAddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // register writes; control takes effect only on update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlStage <= CTRL_RESET;
            ctrlAct   <= CTRL_RESET;
            rdiv      <= RDIV_RESET;
            calStart  <= 1'b0;
            for (int i = 0; i < 5; i++) begin
                chanCfg[i] <= CHAN_RESET;
            end
        end else if (ce) begin
            calStart <= 1'b0;
            if (doWrite) begin
                case (awAddr)
                    ADDR_CTRL: ctrlStage <= merge(ctrlStage, wData, wStrb);
                    ADDR_UPDATE: begin
                        if (wStrb[0] && wData[0]) begin
                            ctrlAct  <= ctrlStage;
                            calStart <= ctrlStage[CTRL_CAL] & ~ctrlAct[CTRL_CAL];
                        end
                    end
                    ADDR_RDIV: rdiv <= merge(rdiv, wData, wStrb) & 32'h0000_03FF;
                    default: begin
                        if (awAddr >= ADDR_CHAN0 && awAddr <= ADDR_CHAN4 && awAddr[1:0] == 2'b00) begin
                            chanCfg[3'((awAddr - ADDR_CHAN0) >> 2)] <= merge(chanCfg[3'((awAddr - ADDR_CHAN0) >> 2)],
                                                                           wData, wStrb);
                        end
                    end
                endcase
            end
        end
    end
    // read channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else if (ce) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    ADDR_CTRL:   s_axi_rdata <= ctrlStage;
                    ADDR_UPDATE: s_axi_rdata <= 32'h0000_0000;
                    ADDR_RDIV:   s_axi_rdata <= rdiv;
                    ADDR_STATUS: s_axi_rdata <= {30'h0, calBusy, calDone};
                    default: begin
                        if (s_axi_araddr >= ADDR_CHAN0 && s_axi_araddr <= ADDR_CHAN4 && s_axi_araddr[1:0] == 2'b00) begin
                            s_axi_rdata <= chanCfg[3'((s_axi_araddr - ADDR_CHAN0) >> 2)];
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= 2'b10;
                        end
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // calibration controller: reference / R / cal divider, then 4400 ticks
    cal_state_t  calState;
    logic [9:0]  rCnt;
    logic [3:0]  dCnt;
    logic [12:0] calCnt;
    wire logic [9:0] rLast = (rdiv[9:0] == 10'h000) ? 10'h000 : rdiv[9:0] - 10'h001;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calState <= CAL_IDLE;
            rCnt     <= 10'h000;
            dCnt     <= 4'h0;
            calCnt   <= 13'h0000;
            calDone  <= 1'b0;
            calBusy  <= 1'b0;
        end else if (ce) begin
            case (calState)
                CAL_IDLE: begin
                    if (calStart) begin
                        calState <= CAL_RUN;
                        calBusy  <= 1'b1;
                        calDone  <= 1'b0;
                        calCnt   <= 13'h0000; // rCnt and dCnt are already back at zero when idle
                    end
                end
                CAL_RUN: begin
                    if (refRise) begin
                        if (rCnt != rLast) begin
                            rCnt <= rCnt + 10'h001;
                        end else begin
                            rCnt <= 10'h000;
                            if (dCnt != calDivRatio(ctrlAct[CTRL_CALDIV_LSB +: 2]) - 4'h1) begin
                                dCnt <= dCnt + 4'h1;
                            end else begin
                                dCnt <= 4'h0;
                                if (calCnt == CAL_LAST) begin
                                    calState <= CAL_IDLE;
                                    calBusy  <= 1'b0;
                                    calDone  <= 1'b1;
                                end else begin
                                    calCnt <= calCnt + 13'h0001;
                                end
                            end
                        end
                    end
                end
                default: calState <= CAL_IDLE;
            endcase
        end
    end
    // source select and pre-divider
    src_sel_t   srcSel;
    logic [2:0] preRatio;
    logic [2:0] preCnt;
    logic       srcPrev;
    logic       divIn;
    assign srcSel   = src_sel_t'(ctrlAct[CTRL_SRC_LSB +: 2]);
    assign preRatio = (ctrlAct[CTRL_PREDIV_LSB +: 3] < PREDIV_MIN) ? PREDIV_MIN :
                      (ctrlAct[CTRL_PREDIV_LSB +: 3] > PREDIV_MAX) ? PREDIV_MAX :
                      ctrlAct[CTRL_PREDIV_LSB +: 3];
    wire logic srcLevel = (srcSel == SRC_OSC_PRE) ? syncB[2] : (srcSel == SRC_BAD) ? 1'b0 : syncB[1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preCnt  <= 3'h0;
            srcPrev <= 1'b0;
            divIn   <= 1'b0;
        end else if (ce) begin
            srcPrev <= srcLevel;
            if (srcSel == SRC_EXT_DIRECT || srcSel == SRC_BAD) begin
                divIn <= srcLevel; // srcLevel stays low for the disallowed code
            end else if (srcLevel & ~srcPrev) begin
                preCnt <= (preCnt >= preRatio - 3'h1) ? 3'h0 : preCnt + 3'h1;
                divIn  <= (preCnt >= preRatio - 3'h1) || (preCnt + 3'h1 < (preRatio >> 1));
            end
        end
    end
    // seven divider stages: 0..4 first stages, 5 and 6 cascade after 3 and 4
    logic [6:0] stOut;
    genvar s;
    generate
        for (s = 0; s < 7; s++) begin : g_stage
            localparam int CH = (s < 5) ? s : s - 2;
            logic [31:0] cfg;
            logic [3:0]  hiN, loM;
            logic        inLvl, inPrev, lvl, stretch, dccOn;
            logic [3:0]  cnt;
            logic [4:0]  dly;
            assign cfg   = chanCfg[CH];
            assign hiN   = (s < 5) ? cfg[CH_N_LSB +: 4] : cfg[CH_N2_LSB +: 4];
            assign loM   = (s < 5) ? cfg[CH_M_LSB +: 4] : cfg[CH_M2_LSB +: 4];
            if (s < 5) begin : g_src
                assign inLvl = divIn;
            end else begin : g_casc
                assign inLvl = stOut[s - 2];
            end
            assign dccOn = ~cfg[CH_DCCOFF] && (loM == hiN + 4'h1);
            // counting on input rising edges, half-cycle stretch on falling edges
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    inPrev  <= 1'b0;
                    lvl     <= 1'b0;
                    cnt     <= 4'h0;
                    dly     <= 5'h00;
                    stretch <= 1'b0;
                end else if (ce) begin
                    inPrev <= inLvl;
                    if (calBusy) begin
                        lvl     <= cfg[CH_START];
                        cnt     <= cfg[CH_START] ? hiN : loM;
                        dly     <= (s < 5) ? cfg[CH_PHASE_LSB +: 5] : 5'h00;
                        stretch <= 1'b0;
                    end else if (inLvl & ~inPrev) begin
                        if (dly != 5'h00) begin
                            dly <= dly - 5'h01;
                        end else if (cnt == 4'h0) begin
                            lvl <= ~lvl;
                            cnt <= lvl ? loM : hiN;
                        end else begin
                            cnt <= cnt - 4'h1;
                        end
                    end else if (~inLvl & inPrev) begin
                        stretch <= lvl & dccOn;
                    end
                end
            end
            assign stOut[s] = ((s < 5) ? cfg[CH_BYP] : cfg[CH_BYP2]) ? inLvl : (lvl | stretch);
        end
    endgenerate
    // registered outputs, start level during a calibration, direct route on single-divider channels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanOut  <= 5'h00;
            syncHold <= 1'b0;
        end else if (ce) begin
            syncHold <= calBusy;
            for (int c = 0; c < 5; c++) begin
                if (calBusy) begin // bypassed and direct channels would otherwise keep toggling
                    chanOut[c] <= chanCfg[c][CH_START];
                end else if (c < 3 && chanCfg[c][CH_DIRECT]) begin
                    chanOut[c] <= srcLevel;
                end else begin
                    chanOut[c] <= (c < 3) ? stOut[c] : stOut[c + 2];
                end
            end
        end
    end
endmodule

/* rtl/vco_cal_pkg.sv */
// constants and types for the oscillator calibration and clock distribution block
package vco_cal_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_UPDATE = 8'h04;
    localparam logic [7:0] ADDR_RDIV   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CHAN0  = 8'h10;
    localparam logic [7:0] ADDR_CHAN4  = 8'h20;
    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0200;
    localparam logic [31:0] RDIV_RESET = 32'h0000_0001;
    localparam logic [31:0] CHAN_RESET = 32'h0000_0011;
    // control register fields
    localparam int CTRL_CAL        = 0;
    localparam int CTRL_CALDIV_LSB = 1;
    localparam int CTRL_SRC_LSB    = 4;
    localparam int CTRL_PREDIV_LSB = 8;
    // channel register fields
    localparam int CH_N_LSB     = 0;
    localparam int CH_M_LSB     = 4;
    localparam int CH_BYP       = 8;
    localparam int CH_DCCOFF    = 9;
    localparam int CH_START     = 10;
    localparam int CH_PHASE_LSB = 11;
    localparam int CH_DIRECT    = 16;
    localparam int CH_N2_LSB    = 20;
    localparam int CH_M2_LSB    = 24;
    localparam int CH_BYP2      = 28;
    // calibration length in calibration clock cycles, minus one
    localparam logic [12:0] CAL_LAST = 13'h112F;
    // pre-divider limits
    localparam logic [2:0] PREDIV_MIN = 3'h2;
    localparam logic [2:0] PREDIV_MAX = 3'h6;
    // distribution source select
    typedef enum logic [1:0] {
        SRC_EXT_PRE    = 2'b00,
        SRC_EXT_DIRECT = 2'b01,
        SRC_OSC_PRE    = 2'b10,
        SRC_BAD        = 2'b11
    } src_sel_t;
    // calibration controller states
    typedef enum logic {
        CAL_IDLE = 1'b0,
        CAL_RUN  = 1'b1
    } cal_state_t;
endpackage

/* verif/vco_cal_and_clock_distribution_assertions.sv */
// port-level assertions for the calibration and distribution block
module vco_cal_checker
    import vco_cal_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // distributed outputs and hold indication
    input wire logic [4:0]  chanOut,
    input wire logic        syncHold,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] holdCnt;
    logic [4:0] sinceUpd;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cycles spent in hold, saturating; the outputs get a few cycles to settle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) holdCnt <= 4'h0;
        else if (!syncHold) holdCnt <= 4'h0;
        else if (holdCnt != 4'hF) holdCnt <= holdCnt + 4'h1;
    end
    // cycles since an update command was taken, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sinceUpd <= 5'h1F;
        else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == ADDR_UPDATE) sinceUpd <= 5'h00;
        else if (sinceUpd != 5'h1F) sinceUpd <= sinceUpd + 5'h01;
    end
    property p_hold_static;
        syncHold && holdCnt >= 4'h8 |-> $stable(chanOut);
    endproperty
    a_hold_static: assert property (p_hold_static) else $error("outputs moved during hold");
    property p_cal_on_request;
        $rose(syncHold) |-> sinceUpd <= 5'd12;
    endproperty
    a_cal_on_request: assert property (p_cal_on_request) else $error("hold began without update");
    property p_awready_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_awready_pulse: assert property (p_awready_pulse) else $error("awready longer than one cycle");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response missing");
    property p_bvalid_stands;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_stands: assert property (p_bvalid_stands) else $error("write response dropped");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data late");
    property p_rdata_stands;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data dropped");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h24 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    c_cal_done: cover property ($fell(syncHold));
    c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind vco_cal_and_clock_distribution vco_cal_checker u_checker (
    .clk(clk), .rst_n(rst_n), .chanOut(chanOut), .syncHold(syncHold),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

/* verif/tb_vco_cal_and_clock_distribution.sv */
// register-driven testbench for the calibration and distribution block
module tb_vco_cal_and_clock_distribution
    import vco_cal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, ce = 1, referenceInput = 0, extClkIn = 0, oscClkIn = 0;
    logic [4:0]  chanOut;
    logic        syncHold, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          miscompares = 0, samples_checked = 0, cycles = 0, refEdges = 0;
    // clocks: ext 8, oscillator 6, reference 4 cycles of clk; pin edges stay off rising clk edges
    always #5 clk = ~clk;
    always #20 referenceInput = ~referenceInput;
    always #40 extClkIn = ~extClkIn;
    always #30 oscClkIn = ~oscClkIn;
    always @(posedge referenceInput) refEdges++;
    vco_cal_and_clock_distribution dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .referenceInput(referenceInput), .extClkIn(extClkIn),
        .oscClkIn(oscClkIn), .chanOut(chanOut), .syncHold(syncHold),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard, two calibrations take about 53000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            $display("unexpected at %0t: run timed out", $time);
            end_of_test();
        end
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp, input int tol);
        samples_checked++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("unexpected at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    // bus write, address and data offered together; slow delays bready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit slow);
        bit awDone;
        bit wDone;
        awDone = 0;
        wDone = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        if (slow) begin
            s_axi_bready <= 1'b1;
            @(posedge clk);
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // bus read into rdv and resp; slow delays rready
    task automatic rd(input logic [7:0] a, input bit slow);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        if (slow) begin
            s_axi_rready <= 1'b1;
            @(posedge clk);
        end
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [31:0] ctrlVal(int src, int pre, int cd, int cal);
        return 32'((pre << CTRL_PREDIV_LSB) | (src << CTRL_SRC_LSB) | (cd << CTRL_CALDIV_LSB) | cal);
    endfunction
    // staged control write followed by the update command
    task automatic setCtrl(input logic [31:0] v);
        wr(ADDR_CTRL, v, 1'b0);
        wr(ADDR_UPDATE, 32'h0000_0001, 1'b0);
    endtask
    // configure one channel, then time one output period in clk cycles
    task automatic run(input int src, input int pre, input int ch, input logic [31:0] v, input int per, input int hi);
        int h;
        int l;
        h = 0;
        l = 0;
        setCtrl(ctrlVal(src, pre, 0, 0));
        wr(ADDR_CHAN0 + 8'(4 * ch), v, 1'b0);
        repeat (100) @(posedge clk);
        while (chanOut[ch] !== 1'b0) @(posedge clk);
        while (chanOut[ch] !== 1'b1) @(posedge clk);
        while (chanOut[ch] === 1'b1) begin
            h++;
            @(posedge clk);
        end
        while (chanOut[ch] === 1'b0) begin
            l++;
            @(posedge clk);
        end
        near(h + l, per, 1);
        if (hi > 0) near(h, hi, 1);
    endtask
    // clear, update, set, update; then watch the hold and count reference edges
    task automatic cal(input int cd, input int expEdges);
        int e0;
        int n;
        setCtrl(ctrlVal(1, 2, cd, 0));
        setCtrl(ctrlVal(1, 2, cd, 1));
        n = 0;
        while (syncHold !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        e0 = refEdges;
        chk({33'h0, syncHold}, 34'h1);
        repeat (20) @(posedge clk);
        chk({32'h0, chanOut[1:0]}, 34'h1);
        rd(ADDR_STATUS, 1'b0);
        chk({resp, rdv}, {2'b00, 32'h0000_0002});
        while (syncHold === 1'b1) @(posedge clk);
        near(refEdges - e0, expEdges, 3);
        rd(ADDR_STATUS, 1'b1);
        chk({resp, rdv}, {2'b00, 32'h0000_0001});
    endtask
    initial begin
        logic [4:0] last;
        int toggles;
        repeat (4) @(posedge clk);
        chk({26'h0, chanOut, syncHold, s_axi_bvalid, s_axi_rvalid}, 34'h0);
        rst_n <= 1'b1;
        // values after reset, the last one read slowly
        rd(ADDR_CTRL, 1'b0);
        chk({resp, rdv}, {2'b00, CTRL_RESET});
        rd(ADDR_RDIV, 1'b0);
        chk({resp, rdv}, {2'b00, RDIV_RESET});
        for (int c = 0; c < 5; c++) begin
            rd(ADDR_CHAN0 + 8'(4 * c), c == 4);
            chk({resp, rdv}, {2'b00, CHAN_RESET});
        end
        // unmapped places are refused
        rd(8'h40, 1'b1);
        chk({resp, rdv}, {2'b10, 32'h0000_0000});
        wr(8'h44, 32'h0000_FFFF, 1'b1);
        chk({32'h0, resp}, 34'h2);
        // divider changes and a staged request alone start nothing
        wr(ADDR_RDIV, 32'h0000_0003, 1'b0);
        wr(ADDR_RDIV, 32'h0000_0001, 1'b0);
        wr(ADDR_CTRL, ctrlVal(1, 2, 0, 1), 1'b0);
        repeat (40) @(posedge clk);
        chk({33'h0, syncHold}, 34'h0);
        rd(ADDR_STATUS, 1'b0);
        chk({resp, rdv}, 34'h0);
        // channel dividers on the external clock, 8 cycles per input period, then on the oscillator, 6 cycles per input period
        run(1, 2, 0, 32'h0000_0221, 40, 16);
        run(1, 2, 0, 32'h0000_0021, 40, 20);
        run(1, 2, 1, 32'h0000_0100, 8, 4);
        run(1, 2, 3, 32'h0000_0000, 32, 16);
        run(1, 2, 4, 32'h0010_0000, 48, 32);
        for (int p = 2; p <= 6; p++) run(0, p, 2, 32'h0000_0100, 8 * p, 0);
        run(2, 2, 2, 32'h0000_0100, 12, 0);
        // the disallowed source leaves every output still
        setCtrl(ctrlVal(3, 2, 0, 0));
        repeat (60) @(posedge clk);
        last = chanOut;
        toggles = 0;
        repeat (100) begin
            @(posedge clk);
            if (chanOut !== last) toggles++;
            last = chanOut;
        end
        near(toggles, 0, 0);
        run(0, 4, 0, 32'h0001_0021, 8, 4);
        // calibrations with channel 0 starting high and channel 1 low
        wr(ADDR_CHAN0, 32'h0000_0421, 1'b0);
        wr(ADDR_CHAN0 + 8'h04, 32'h0000_0021, 1'b0);
        cal(0, 4400);
        // a further update with the request still set starts nothing
        setCtrl(ctrlVal(1, 2, 0, 1));
        repeat (40) @(posedge clk);
        chk({33'h0, syncHold}, 34'h0);
        run(1, 2, 0, 32'h0000_0421, 40, 20);
        cal(1, 8800);
        end_of_test();
    end
endmodule
